// ### logic/exec_unit_pkg.sv
package exec_unit_pkg;

  // ----------------------------------------------------------------
  // opcodes (register form; immediate form sets bit 0 where allowed)
  // ----------------------------------------------------------------
  localparam logic [7:0] SignedFinalStepOp = 8'h66;
  localparam logic [7:0] UnsignedStepOp = 8'h74;
  localparam logic [7:0] IntProductLowUnsignedOp = 8'hE2;
  localparam logic [7:0] IntProductLowSignedOp = 8'hE0;
  localparam logic [7:0] IntProductHighSignedOp = 8'hDE;
  localparam logic [7:0] IntProductHighUnsignedOp = 8'hDF;
  localparam logic [7:0] NandOp = 8'h9A;
  localparam logic [7:0] NorOp = 8'h98;
  localparam logic [7:0] OrOp = 8'h92;
  localparam logic [7:0] LoadIndirectPointersOp = 8'h9E;
  localparam logic [7:0] ShiftLeftZeroFillOp = 8'h80;
  localparam logic [7:0] FloatRootOp = 8'hE5;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int OpcodeLsb = 24;
  localparam int TargetLsb = 16;
  localparam int FirstLsb = 8;
  localparam int SecondLsb = 0;
  localparam int FormatLsb = 0;
  localparam int ShiftCountBits = 5;

  // ----------------------------------------------------------------
  // source format select codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] FormatSingle = 2'h1;
  localparam logic [1:0] FormatDouble = 2'h2;
  localparam logic [7:0] PointerResetValue = 8'h00;
  localparam logic [31:0] ExtensionResetValue = 32'h0000_0000;

  // trap identities presented to the trap sequencer
  typedef enum logic [3:0] {
    TrapNone,
    TrapProductLowUnsigned,
    TrapProductLowSigned,
    TrapProductHighSigned,
    TrapProductHighUnsigned,
    TrapFloatRoot,
    TrapProtection,
    TrapIllegalFormat
  } trap_kind_t;

  typedef struct packed {
    logic valid;
    logic [31:0] instruction;
    logic [31:0] firstSource;
    logic [31:0] secondSource;
    logic [7:0] firstNumber;
    logic [7:0] secondNumber;
    logic [7:0] targetNumber;
  } issue_t;

  typedef struct packed {
    logic writeEnable;
    logic [7:0] writeNumber;
    logic [31:0] writeData;
    logic flagWrite;
    logic overflowFlag;
    logic negativeFlag;
    logic zeroFlag;
    logic carryFlag;
  } result_t;

  typedef struct packed {
    logic raise;
    trap_kind_t kind;
  } trap_t;

endpackage : exec_unit_pkg

// ### logic/multiply_logic_shift_exec_unit.sv
`timescale 1ns/1ps
// Operation
// - signed last step subtracts when extension LSB set
// - signed last step shifts right, true-sign fill
// - upper word to target, lower to extension
// - unsigned step adds when extension LSB set
// - unsigned step fills top bit with carry
// - literal select takes zero-extended immediate
// - low unsigned product to target
// - low signed product to target
// - high signed product to target
// - high unsigned product to target
// - extension undefined after full multiply
// - full multiplies trap, pointers get operand numbers
// - nand writes complemented and
// - nor writes complemented or
// - or writes plain or
// - pointer load takes A, B, C numbers
// - user-mode pointer load of protected register traps
// - new pointers take effect after delay
// - left shift by low five bits, zero fill
// - format 01 single, 10 double, others reserved
// - double root uses register pairs
// - root rounded by environment rounding mode
// - root traps, pointers get source, format, target
module multiply_logic_shift_exec_unit (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // issue from decode with register file operands
  input exec_unit_pkg::issue_t issue,
  input wire logic userMode,
  input wire logic [255:0] bankProtect,
  input wire logic [1:0] roundModeField,
  // results to register file and status
  output exec_unit_pkg::result_t result,
  output exec_unit_pkg::trap_t trap,
  output logic [31:0] extensionValue,
  output logic [7:0] indirectPtrA,
  output logic [7:0] indirectPtrB,
  output logic [7:0] indirectPtrC,
  output logic [1:0] trapRoundMode,
  output logic trapDoublePair
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [7:0] opcode;
  logic [7:0] opcodeBase;
  logic literalSel;
  logic [31:0] secondSrc;
  logic [1:0] sourceFormatSel;

  assign opcode = issue.instruction[exec_unit_pkg::OpcodeLsb +: 8];
  assign literalSel = opcode[0];
  assign opcodeBase = {opcode[7:1], 1'b0};
  assign sourceFormatSel = issue.instruction[exec_unit_pkg::FormatLsb +: 2];

  // immediate form zero-extends the low byte
  // the high unsigned product and root codes have bit 0 set but no literal form
  always_comb begin
    if (literalSel && opcode != exec_unit_pkg::IntProductHighUnsignedOp
        && opcode != exec_unit_pkg::FloatRootOp) begin
      secondSrc = {24'h00_0000, issue.instruction[exec_unit_pkg::SecondLsb +: 8]};
    end else begin
      secondSrc = issue.secondSource;
    end
  end

  // ----------------------------------------------------------------
  // multiply steps
  // ----------------------------------------------------------------
  logic [31:0] extension_q;
  logic [31:0] extension_d;
  logic [32:0] stepAdd;
  logic [31:0] stepSub;
  logic subOverflow;
  logic addOverflow;
  logic [63:0] signedShifted;
  logic [63:0] unsignedShifted;
  logic [31:0] addend;

  assign addend = extension_q[0] ? issue.firstSource : 32'h0000_0000;
  assign stepAdd = {1'b0, secondSrc} + {1'b0, addend};
  assign addOverflow = (secondSrc[31] == addend[31]) && (stepAdd[31] != addend[31]);
  // subtrahend is the same gated first source
  assign stepSub = secondSrc - addend;
  assign subOverflow = (secondSrc[31] != addend[31]) && (stepSub[31] != secondSrc[31]);
  // true sign: sign bit flipped on overflow
  assign signedShifted = {stepSub[31] ^ subOverflow, stepSub, extension_q[31:1]};
  assign unsignedShifted = {stepAdd[32], stepAdd[31:0], extension_q[31:1]};

  // ----------------------------------------------------------------
  // logic and shift
  // ----------------------------------------------------------------
  logic [31:0] nandValue;
  logic [31:0] norValue;
  logic [31:0] orValue;
  logic [31:0] shiftValue;

  assign nandValue = ~(issue.firstSource & secondSrc);
  assign norValue = ~(issue.firstSource | secondSrc);
  assign orValue = issue.firstSource | secondSrc;
  assign shiftValue = issue.firstSource << secondSrc[exec_unit_pkg::ShiftCountBits-1:0];

  // ----------------------------------------------------------------
  // protection check for pointer load
  // ----------------------------------------------------------------
  // one protected name among the three is enough to refuse the whole load
  logic protectHit;
  assign protectHit = userMode && (bankProtect[issue.firstNumber]
    || bankProtect[issue.secondNumber] || bankProtect[issue.targetNumber]);

  // ----------------------------------------------------------------
  // result selection
  // ----------------------------------------------------------------
  exec_unit_pkg::result_t result_d;
  exec_unit_pkg::trap_t trap_d;
  logic ptrLoad;
  logic [7:0] ptrA;
  logic [7:0] ptrB;
  logic [7:0] ptrC;
  logic [31:0] value;
  logic flagsAll;
  logic flagsNz;
  logic stepOvf;
  logic stepCarry;

  always_comb begin
    result_d = '0;
    trap_d = '0;
    extension_d = extension_q;
    ptrLoad = 1'b0;
    ptrA = issue.firstNumber;
    ptrB = issue.secondNumber;
    ptrC = issue.targetNumber;
    value = 32'h0000_0000;
    flagsAll = 1'b0;
    flagsNz = 1'b0;
    stepOvf = 1'b0;
    stepCarry = 1'b0;
    if (issue.valid) begin
      case (opcodeBase)
        exec_unit_pkg::SignedFinalStepOp: begin
          value = signedShifted[63:32];
          extension_d = signedShifted[31:0];
          flagsAll = 1'b1;
          stepOvf = subOverflow;
          // carry reads as no borrow, the same sense as a plain subtract
          stepCarry = secondSrc >= addend;
        end
        exec_unit_pkg::UnsignedStepOp: begin
          value = unsignedShifted[63:32];
          extension_d = unsignedShifted[31:0];
          flagsAll = 1'b1;
          stepOvf = addOverflow;
          stepCarry = stepAdd[32];
        end
        exec_unit_pkg::NandOp: begin
          value = nandValue;
          flagsNz = 1'b1;
        end
        exec_unit_pkg::NorOp: begin
          value = norValue;
          flagsNz = 1'b1;
        end
        exec_unit_pkg::OrOp: begin
          value = orValue;
          flagsNz = 1'b1;
        end
        exec_unit_pkg::ShiftLeftZeroFillOp: begin
          value = shiftValue;
        end
        default: begin
        end
      endcase
      // full multiplies: register-only forms, emulated in software
      // extension register is left untouched, software must not rely on it
      case (opcode)
        exec_unit_pkg::IntProductLowUnsignedOp: begin
          trap_d = '{raise: 1'b1, kind: exec_unit_pkg::TrapProductLowUnsigned};
          ptrLoad = 1'b1;
        end
        exec_unit_pkg::IntProductLowSignedOp: begin
          trap_d = '{raise: 1'b1, kind: exec_unit_pkg::TrapProductLowSigned};
          ptrLoad = 1'b1;
        end
        exec_unit_pkg::IntProductHighSignedOp: begin
          trap_d = '{raise: 1'b1, kind: exec_unit_pkg::TrapProductHighSigned};
          ptrLoad = 1'b1;
        end
        exec_unit_pkg::IntProductHighUnsignedOp: begin
          trap_d = '{raise: 1'b1, kind: exec_unit_pkg::TrapProductHighUnsigned};
          ptrLoad = 1'b1;
        end
        exec_unit_pkg::LoadIndirectPointersOp: begin
          if (protectHit) begin
            trap_d = '{raise: 1'b1, kind: exec_unit_pkg::TrapProtection};
          end else begin
            ptrLoad = 1'b1;
          end
        end
        exec_unit_pkg::FloatRootOp: begin
          if (sourceFormatSel == exec_unit_pkg::FormatSingle
              || sourceFormatSel == exec_unit_pkg::FormatDouble) begin
            trap_d = '{raise: 1'b1, kind: exec_unit_pkg::TrapFloatRoot};
            ptrLoad = 1'b1;
            ptrB = {6'h00, sourceFormatSel};
          end else begin
            trap_d = '{raise: 1'b1, kind: exec_unit_pkg::TrapIllegalFormat};
          end
        end
        default: begin
        end
      endcase
      // the write gate reads trap_d, so a trap always beats a prepared write
      if (!trap_d.raise && (flagsAll || flagsNz || opcodeBase ==
          exec_unit_pkg::ShiftLeftZeroFillOp)) begin
        result_d.writeEnable = 1'b1;
        result_d.writeNumber = issue.targetNumber;
        result_d.writeData = value;
        result_d.flagWrite = flagsAll || flagsNz;
        result_d.negativeFlag = value[31];
        result_d.zeroFlag = (value == 32'h0000_0000);
        result_d.overflowFlag = stepOvf;
        result_d.carryFlag = stepCarry;
      end
      // a trap keeps the step chain intact so the emulator can resume it
      if (trap_d.raise) begin
        extension_d = extension_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // pointers: two-stage pipeline so the next instruction sees old values
  // ----------------------------------------------------------------
  logic pend_q;
  logic [23:0] pendPtr_q;
  logic [23:0] ptr_q;
  logic pend_d;
  logic [23:0] pendPtr_d;
  logic [23:0] ptr_d;
  logic rootDouble_q;
  logic rootDouble_d;
  logic [1:0] rootRound_q;
  logic [1:0] rootRound_d;

  always_comb begin
    // a load right behind another simply overwrites the pending copy
    pend_d = ptrLoad;
    pendPtr_d = ptrLoad ? {ptrA, ptrB, ptrC} : pendPtr_q;
    ptr_d = pend_q ? pendPtr_q : ptr_q;
    rootDouble_d = rootDouble_q;
    rootRound_d = rootRound_q;
    if (trap_d.kind == exec_unit_pkg::TrapFloatRoot) begin
      // emulator operates on register pairs for the double format only and rounds by the captured mode
      rootDouble_d = (sourceFormatSel == exec_unit_pkg::FormatDouble);
      rootRound_d = roundModeField;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pend_q <= 1'b0;
      pendPtr_q <= {3{exec_unit_pkg::PointerResetValue}};
      ptr_q <= {3{exec_unit_pkg::PointerResetValue}};
      rootDouble_q <= 1'b0;
      rootRound_q <= 2'h0;
    end else begin
      pend_q <= pend_d;
      pendPtr_q <= pendPtr_d;
      ptr_q <= ptr_d;
      rootDouble_q <= rootDouble_d;
      rootRound_q <= rootRound_d;
    end
  end

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      extension_q <= exec_unit_pkg::ExtensionResetValue;
      result <= '0;
      trap <= '0;
    end else begin
      extension_q <= extension_d;
      result <= result_d;
      trap <= trap_d;
    end
  end

  assign extensionValue = extension_q;
  assign indirectPtrA = ptr_q[23:16];
  assign indirectPtrB = ptr_q[15:8];
  assign indirectPtrC = ptr_q[7:0];
  assign trapDoublePair = rootDouble_q;
  assign trapRoundMode = rootRound_q;

endmodule : multiply_logic_shift_exec_unit

// ### test/exec_unit_checker.sv
`timescale 1ns/1ps
module exec_unit_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // issue
  input exec_unit_pkg::issue_t issue,
  input wire logic userMode,
  input wire logic [255:0] bankProtect,
  input wire logic [1:0] roundModeField,
  // results
  input exec_unit_pkg::result_t result,
  input exec_unit_pkg::trap_t trap,
  input wire logic [31:0] extensionValue,
  input wire logic [7:0] indirectPtrA,
  input wire logic [7:0] indirectPtrB,
  input wire logic [7:0] indirectPtrC,
  input wire logic [1:0] trapRoundMode,
  input wire logic trapDoublePair
);
  logic [7:0] op;
  logic [1:0] fmt;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] x;
  logic [32:0] s;
  logic [63:0] stepX;
  logic [31:0] lx;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // reference values
  // ----------------------------------------------------------------
  always_comb begin
    op = issue.instruction[31:24];
    fmt = issue.instruction[1:0];
    a = issue.firstSource;
    b = op[0] ? {24'h0, issue.instruction[7:0]} : issue.secondSource;
    x = extensionValue[0] ? a : 32'h0;
    s = op[4] ? {1'b0, b} + {1'b0, x} : {1'b0, b} - {1'b0, x};
    // subtract fill is the sign corrected for overflow
    stepX = {op[4] ? s[32] : s[31] ^ ((b[31] ^ x[31]) & (s[31] ^ b[31])), s[31:0],
      extensionValue[31:1]};
    lx = op[3] ? (op[1] ? ~(a & b) : ~(a | b)) : (op[4] ? a | b : a << b[4:0]);
  end
  sequence goIdle(go);
    go ##1 !issue.valid;
  endsequence
  sequence ptrsAre(logic [7:0] pa, logic [7:0] pb, logic [7:0] pc);
    indirectPtrA == pa && indirectPtrB == pb && indirectPtrC == pc;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  reset_clear_a: assert property ($fell(reset) |-> result == '0 && trap == '0
    && extensionValue == 32'h0) else $error("outputs not clear after reset");
  step_out_a: assert property (
    issue.valid && op[7:1] inside {7'h33, 7'h3A} |=> result.writeEnable
    && {result.writeData, extensionValue} == $past(stepX)) else $error("step result wrong");
  logic_out_a: assert property (
    issue.valid && op[7:1] inside {7'h4D, 7'h4C, 7'h49, 7'h40} |=> result.writeEnable
    && result.writeData == $past(lx)) else $error("logic or shift result wrong");
  mul_trap_a: assert property (
    issue.valid && op inside {8'hE0, 8'hE2, 8'hDE, 8'hDF} |=> trap.raise
    && !result.writeEnable && !result.flagWrite) else $error("full multiply not trapped");
  mul_ptrs_a: assert property (
    goIdle(issue.valid && op inside {8'hE0, 8'hE2, 8'hDE, 8'hDF}) |=> ptrsAre(
    $past(issue.firstNumber, 2), $past(issue.secondNumber, 2), $past(issue.targetNumber, 2)))
    else $error("trap pointers wrong");
  ptr_load_a: assert property (
    goIdle(!$past(issue.valid) && issue.valid && op == 8'h9E && !userMode)
    |-> $stable(indirectPtrA) && $stable(indirectPtrC) ##1 ptrsAre($past(issue.firstNumber, 2),
    $past(issue.secondNumber, 2), $past(issue.targetNumber, 2))) else $error("pointer load wrong");
  protect_trap_a: assert property (
    issue.valid && op == 8'h9E && userMode && (bankProtect[issue.firstNumber]
    || bankProtect[issue.secondNumber] || bankProtect[issue.targetNumber]) |=> trap.raise
    && trap.kind == exec_unit_pkg::TrapProtection) else $error("protection trap missing");
  root_trap_a: assert property (
    goIdle(issue.valid && op == 8'hE5 && fmt[1] != fmt[0]) |-> trap.raise
    && trap.kind == exec_unit_pkg::TrapFloatRoot ##1 ptrsAre($past(issue.firstNumber, 2),
    {6'h0, $past(fmt, 2)}, $past(issue.targetNumber, 2)) ##0 (trapDoublePair == $past(fmt[1], 2)
    && trapRoundMode == $past(roundModeField, 2))) else $error("root trap wrong");
  bad_format_a: assert property (
    issue.valid && op == 8'hE5 && fmt[1] == fmt[0] |=> trap.raise
    && trap.kind == exec_unit_pkg::TrapIllegalFormat) else $error("reserved format accepted");
endmodule : exec_unit_checker

bind multiply_logic_shift_exec_unit exec_unit_checker i_exec_unit_checker (.mclk(mclk),
  .reset(reset), .issue(issue), .userMode(userMode), .bankProtect(bankProtect),
  .roundModeField(roundModeField), .result(result), .trap(trap),
  .extensionValue(extensionValue), .indirectPtrA(indirectPtrA), .indirectPtrB(indirectPtrB),
  .indirectPtrC(indirectPtrC), .trapRoundMode(trapRoundMode), .trapDoublePair(trapDoublePair));

// ### test/issue_model.sv
`timescale 1ns/1ps
module issue_model (
  // clock
  input wire logic mclk,
  // bench side
  input wire logic go,
  input wire logic [31:0] instr,
  input wire logic loadEn,
  input wire logic [7:0] loadNum,
  input wire logic [31:0] loadData,
  // unit side
  input exec_unit_pkg::result_t result,
  output exec_unit_pkg::issue_t issue
);
  logic [31:0] regs [256];
  // unit write-back lands after a bench preload at the same edge
  always_ff @(posedge mclk) begin
    if (loadEn) begin
      regs[loadNum] <= loadData;
    end
    if (result.writeEnable) begin
      regs[result.writeNumber] <= result.writeData;
    end
  end
  // operands are scrambled while no instruction is offered
  always_comb begin
    issue.valid = go;
    issue.instruction = instr;
    issue.targetNumber = instr[23:16];
    issue.firstNumber = instr[15:8];
    issue.secondNumber = instr[7:0];
    issue.firstSource = go ? regs[instr[15:8]] : ~regs[instr[15:8]];
    issue.secondSource = go ? regs[instr[7:0]] : ~regs[instr[7:0]];
  end
endmodule : issue_model

// ### test/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errCount++; \
  $display("Error %0t: got %h want %h", $time, g, e); end end
module tb;
  typedef struct packed {logic [7:0] op; logic [31:0] a; logic [31:0] b; logic [31:0] w;} row_t;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic go = 1'b0;
  logic [31:0] instr = 32'h0;
  logic loadEn = 1'b0;
  logic [7:0] loadNum = 8'h0;
  logic [31:0] loadData = 32'h0;
  logic userMode = 1'b0;
  logic [255:0] bankProtect = '0;
  logic [1:0] roundModeField = 2'h0;
  exec_unit_pkg::issue_t issue;
  exec_unit_pkg::result_t result;
  exec_unit_pkg::trap_t trap;
  logic [31:0] extensionValue;
  logic [7:0] pA, pB, pC;
  logic [1:0] trapRoundMode;
  logic trapDoublePair;
  int errCount = 0;
  int nTests = 0;
  logic [7:0] op8;
  logic [31:0] q;
  logic [63:0] w;
  exec_unit_pkg::trap_kind_t wantKind;
  logic [7:0] mulOp [4] = '{8'hE2, 8'hE0, 8'hDE, 8'hDF};
  row_t rows [8] = '{
    '{8'h9A, 32'hF0F0_1234, 32'hFF00_00FF, 32'h0FFF_FFCB},
    '{8'h9B, 32'h0000_00F0, 32'h0000_003C, 32'hFFFF_FFCF},
    '{8'h98, 32'h1234_0000, 32'h0000_5678, 32'hEDCB_A987},
    '{8'h99, 32'hFFFF_FF00, 32'h0000_000F, 32'h0000_00F0},
    '{8'h92, 32'h8000_0001, 32'h0000_0100, 32'h8000_0101},
    '{8'h93, 32'h0000_0000, 32'h0000_00FF, 32'h0000_00FF},
    '{8'h80, 32'h0000_0003, 32'h0000_0021, 32'h0000_0006},
    '{8'h81, 32'hFFFF_FFFF, 32'h0000_001F, 32'h8000_0000}};
  multiply_logic_shift_exec_unit i_multiply_logic_shift_exec_unit (.mclk(mclk), .reset(reset),
    .issue(issue), .userMode(userMode), .bankProtect(bankProtect),
    .roundModeField(roundModeField), .result(result), .trap(trap),
    .extensionValue(extensionValue), .indirectPtrA(pA), .indirectPtrB(pB), .indirectPtrC(pC),
    .trapRoundMode(trapRoundMode), .trapDoublePair(trapDoublePair));
  issue_model i_issue_model (.mclk(mclk), .go(go), .instr(instr), .loadEn(loadEn),
    .loadNum(loadNum), .loadData(loadData), .result(result), .issue(issue));
  always #5 mclk = ~mclk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [63:0] stepRef(input logic [7:0] o, input logic [31:0] a, b, qv);
    logic [31:0] x;
    logic [32:0] s;
    x = qv[0] ? a : 32'h0;
    s = o[4] ? {1'b0, b} + {1'b0, x} : {1'b0, b} - {1'b0, x};
    return {o[4] ? s[32] : s[31] ^ ((b[31] ^ x[31]) & (s[31] ^ b[31])), s[31:0], qv[31:1]};
  endfunction : stepRef
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask : tick
  task automatic load(input logic [7:0] n, input logic [31:0] d);
    @(posedge mclk);
    loadEn <= 1'b1;
    loadNum <= n;
    loadData <= d;
    @(posedge mclk);
    loadEn <= 1'b0;
  endtask : load
  // result is looked at in the single cycle that it stands
  task automatic run(input logic [31:0] i);
    @(posedge mclk);
    go <= 1'b1;
    instr <= i;
    @(posedge mclk);
    go <= 1'b0;
    #1;
  endtask : run
  task automatic stopTest;
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stopTest
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    tick;
    `CHK({result, trap, extensionValue, pA, pB, pC}, '0)
    load(8'h01, 32'h8000_0001);
    load(8'h02, 32'h7FFF_FFFF);
    // back-to-back steps chain through the extension register
    q = 32'h0;
    for (int k = 0; k <= 48; k++) begin
      @(posedge mclk);
      op8 = k < 40 ? 8'h74 : (k < 44 ? 8'h67 : 8'h66);
      go <= (k < 48);
      instr <= {op8, 8'hC8, 8'h01, op8[0] ? 8'h81 : 8'h02};
      #1;
      if (k > 0) begin
        `CHK({result.writeData, extensionValue}, w)
        `CHK({result.flagWrite, result.negativeFlag}, {1'b1, w[63]})
        if (k <= 40) begin
          `CHK(result.carryFlag, w[63])
        end
        q = w[31:0];
      end
      w = stepRef(op8, 32'h8000_0001, op8[0] ? 32'h81 : 32'h7FFF_FFFF, q);
    end
    foreach (rows[k]) begin
      load(8'h01, rows[k].a);
      load(8'h02, rows[k].b);
      run({rows[k].op, 8'hC8, 8'h01, rows[k].op[0] ? rows[k].b[7:0] : 8'h02});
      `CHK({result.writeEnable, result.writeData}, {1'b1, rows[k].w})
      `CHK({result.writeNumber, trap.raise}, {8'hC8, 1'b0})
      `CHK(result.flagWrite, rows[k].op[7:1] != 7'h40)
      `CHK({result.negativeFlag, result.zeroFlag}, {rows[k].w[31], rows[k].w == '0})
    end
    for (int k = 0; k < 4; k++) begin
      run({mulOp[k], 8'h30 + 8'(k), 8'h10, 8'h20});
      `CHK(trap, {1'b1, exec_unit_pkg::trap_kind_t'(4'(k + 1))})
      `CHK({result.writeEnable, result.flagWrite}, 2'b00)
      `CHK(extensionValue, q)
      tick;
      `CHK({pA, pB, pC}, {8'h10, 8'h20, 8'h30 + 8'(k)})
    end
    @(posedge mclk);
    userMode <= 1'b1;
    bankProtect[8'h52] <= 1'b1;
    run(32'h9E53_5152);
    `CHK(trap, {1'b1, exec_unit_pkg::TrapProtection})
    tick;
    `CHK({pA, pB, pC}, 24'h10_20_33)
    @(posedge mclk);
    userMode <= 1'b0;
    run(32'h9E53_5152);
    `CHK({trap.raise, pA}, {1'b0, 8'h10})
    tick;
    `CHK({pA, pB, pC}, 24'h51_52_53)
    for (int f = 0; f < 4; f++) begin
      @(posedge mclk);
      roundModeField <= 2'(3 - f);
      run({8'hE5, 8'h60, 8'h44, 6'h0, 2'(f)});
      wantKind = (f == 1 || f == 2) ? exec_unit_pkg::TrapFloatRoot
        : exec_unit_pkg::TrapIllegalFormat;
      `CHK(trap.kind, wantKind)
      `CHK({result.writeEnable, result.flagWrite}, 2'b00)
      tick;
      if (f == 1 || f == 2) begin
        `CHK({pA, pB, pC}, {8'h44, 6'h0, 2'(f), 8'h60})
        `CHK({trapDoublePair, trapRoundMode}, {f == 2, 2'(3 - f)})
      end
    end
    run(32'hFF01_0102);
    `CHK({result.writeEnable, trap.raise}, 2'b00)
    @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    tick;
    `CHK({result, trap, extensionValue, pA, pB, pC}, '0)
    stopTest;
  end
endmodule : tb
